// ---- design/esp_serial_port.sv ----
// Purpose: asynchronous serial transmitter with baud generator and autobaud calibration
// Assumes: synchronous rx_line input, register port with read data one cycle later
// Notes:   receiver data path is outside this block; only its flag is kept here
//
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module esp_serial_port
    import esp_pkg::*;
(
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       reset,
    // Register port
    input  wire logic [2:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    // Serial lines
    input  wire logic       rx_line,
    output logic            tx_line
);

    function automatic logic [9:0] presc_len(input logic wide, input logic hs,
                                             input logic slow);
        logic [9:0] len;
        len = PRESC_X64;
        case ({wide, hs})
            2'b01:   len = PRESC_X16;
            2'b10:   len = PRESC_X16;
            2'b11:   len = PRESC_X4;
            default: len = PRESC_X64;
        endcase
        if (slow) begin
            len = 10'(((len + 10'h001) << ABD_SLOW_SHIFT) - 10'h001);
        end
        return len;
    endfunction

    function automatic logic wr_at(input logic [2:0] a, input logic w,
                                   input logic [2:0] target);
        return w && (a == target);
    endfunction

    // Control registers
    logic       nine_bit_tx_enable;
    logic       transmit_enable;
    logic       sync_mode;
    logic       high_speed_baud_select;
    logic       tx_ninth_bit_value;
    logic       serial_port_enable;
    logic       wide_divisor_select;
    logic       wake_on_break_enable;
    logic       autobaud_arm;
    logic       autobaud_overflow_flag;
    logic [7:0] baud_divisor_low;
    logic [7:0] baud_divisor_high;
    // Transmit path
    logic [7:0]    transmit_buffer;
    logic          tx_ninth_latched;
    logic          buf_full;
    logic          transmit_buffer_empty_flag;
    logic          receive_flag;
    logic          transmit_enable_prev;
    esp_tx_state_t tx_state;
    logic [9:0]    transmit_shift_reg;
    logic [3:0]    bits_left;
    // Baud generator and calibration
    logic [9:0]     presc_cnt;
    logic [15:0]    div_cnt;
    esp_abd_state_t abd_state;
    logic [2:0]     edge_cnt;
    logic           rx_prev;

    logic        async_on;
    logic        abd_counting;
    logic        presc_tick;
    logic        bit_tick;
    logic        tx_load;
    logic        buf_write;
    logic        rx_rise;
    logic        rx_fall;
    logic        abd_done;
    logic        abd_arm_write;
    logic [15:0] divisor;
    logic [9:0]  presc_end;

    assign async_on      = serial_port_enable && !sync_mode;
    assign divisor       = wide_divisor_select ? {baud_divisor_high, baud_divisor_low}
                                               : {8'h00, baud_divisor_low};
    assign abd_counting  = (abd_state == ABD_COUNT);
    assign presc_end     = presc_len(wide_divisor_select, high_speed_baud_select,
                                     abd_counting);
    assign presc_tick    = (presc_cnt == presc_end);
    assign bit_tick      = presc_tick && (div_cnt == 16'h0000);
    assign rx_rise       = rx_line && !rx_prev;
    assign rx_fall       = !rx_line && rx_prev;
    assign abd_done      = abd_counting && rx_rise && (edge_cnt == ABD_LAST_EDGE);
    assign abd_arm_write = wr_at(addr, wr, ADDR_BAUD_CTRL) && wdata[BIT_AUTOBAUD_ARM]
                           && !autobaud_arm;
    assign buf_write     = wr_at(addr, wr, ADDR_TX_BUFFER) && !autobaud_arm;
    assign tx_load       = (tx_state == TX_IDLE) && buf_full && async_on
                           && transmit_enable && !autobaud_arm;

    // Configuration bits
    always_ff @(posedge mclk) begin
        if (reset) begin
            nine_bit_tx_enable     <= 1'b0;
            transmit_enable        <= 1'b0;
            sync_mode              <= 1'b0;
            high_speed_baud_select <= 1'b0;
            tx_ninth_bit_value     <= 1'b0;
            serial_port_enable     <= 1'b0;
            wide_divisor_select    <= 1'b0;
            wake_on_break_enable   <= 1'b0;
        end else begin
            if (wr_at(addr, wr, ADDR_TX_STATUS)) begin
                nine_bit_tx_enable     <= wdata[BIT_NINE_BIT];
                transmit_enable        <= wdata[BIT_TX_ENABLE];
                sync_mode              <= wdata[BIT_SYNC_MODE];
                high_speed_baud_select <= wdata[BIT_HIGH_SPEED];
                tx_ninth_bit_value     <= wdata[BIT_NINTH_VALUE];
            end
            if (wr_at(addr, wr, ADDR_PORT_CTRL)) begin
                serial_port_enable <= wdata[BIT_PORT_ENABLE];
            end
            if (wr_at(addr, wr, ADDR_BAUD_CTRL)) begin
                wide_divisor_select  <= wdata[BIT_WIDE_DIVISOR];
                wake_on_break_enable <= wdata[BIT_WAKE_ON_BREAK];
            end
        end
    end

    // Arm bit and overflow flag; hardware clear of arm and set of overflow win over software
    always_ff @(posedge mclk) begin
        if (reset) begin
            autobaud_arm           <= 1'b0;
            autobaud_overflow_flag <= 1'b0;
        end else begin
            if (abd_done) begin
                autobaud_arm <= 1'b0;
            end else if (wr_at(addr, wr, ADDR_BAUD_CTRL)) begin
                autobaud_arm <= wdata[BIT_AUTOBAUD_ARM];
            end
            if (abd_counting && presc_tick && ({baud_divisor_high, baud_divisor_low}
                                               == DIV_MAX)) begin
                autobaud_overflow_flag <= 1'b1;
            end else if (wr_at(addr, wr, ADDR_BAUD_CTRL)) begin
                autobaud_overflow_flag <= wdata[BIT_ABD_OVERFLOW];
            end
        end
    end

    // Divisor bytes: software load, cleared on arm, counter while calibrating
    always_ff @(posedge mclk) begin
        if (reset) begin
            baud_divisor_low  <= RESET_BYTE;
            baud_divisor_high <= RESET_BYTE;
        end else if (abd_arm_write) begin
            baud_divisor_low  <= RESET_BYTE;
            baud_divisor_high <= RESET_BYTE;
        end else if (abd_counting && presc_tick) begin
            // Full 16-bit count whatever the width select; wraps to zero
            {baud_divisor_high, baud_divisor_low} <=
                16'({baud_divisor_high, baud_divisor_low} + 16'h0001);
        end else begin
            if (wr_at(addr, wr, ADDR_DIV_LOW)) begin
                baud_divisor_low <= wdata;
            end
            if (wr_at(addr, wr, ADDR_DIV_HIGH)) begin
                baud_divisor_high <= wdata;
            end
        end
    end

    // Baud generator; restarted at each frame so bit times are whole
    always_ff @(posedge mclk) begin
        if (reset || abd_arm_write) begin
            presc_cnt <= 10'h000;
            div_cnt   <= 16'h0000;
        end else if (tx_load) begin
            // Start bit gets a full bit time, not a single step
            presc_cnt <= 10'h000;
            div_cnt   <= divisor;
        end else if (presc_tick) begin
            presc_cnt <= 10'h000;
            div_cnt   <= (div_cnt == 16'h0000) ? divisor : 16'(div_cnt - 16'h0001);
        end else begin
            presc_cnt <= 10'(presc_cnt + 10'h001);
        end
    end

    // Transmit buffer
    always_ff @(posedge mclk) begin
        if (reset) begin
            transmit_buffer  <= RESET_BYTE;
            tx_ninth_latched <= 1'b0;
            buf_full         <= 1'b0;
        end else if (buf_write) begin
            transmit_buffer  <= wdata;
            tx_ninth_latched <= tx_ninth_bit_value;
            buf_full         <= 1'b1;
        end else if (tx_load) begin
            buf_full <= 1'b0;
        end
    end

    // Buffer-empty flag lags the buffer by one cycle; no software clear
    always_ff @(posedge mclk) begin
        if (reset) begin
            transmit_enable_prev                  <= 1'b0;
            transmit_buffer_empty_flag <= 1'b0;
        end else begin
            transmit_enable_prev                  <= transmit_enable;
            transmit_buffer_empty_flag <= transmit_enable
                                          && (!buf_full || !transmit_enable_prev);
        end
    end

    // Transmit shift machine
    always_ff @(posedge mclk) begin
        if (reset || !async_on) begin
            tx_state           <= TX_IDLE;
            transmit_shift_reg <= 10'h3FF;
            bits_left          <= 4'h0;
            tx_line            <= 1'b1;
        end else begin
            case (tx_state)
                TX_IDLE: begin
                    tx_line <= 1'b1;
                    if (tx_load) begin
                        tx_state  <= TX_SHIFT;
                        tx_line   <= 1'b0;
                        // Ninth bit is plain data; no parity is formed here
                        transmit_shift_reg <= nine_bit_tx_enable
                            ? {1'b1, tx_ninth_latched, transmit_buffer}
                            : {2'b11, transmit_buffer};
                        bits_left <= nine_bit_tx_enable ? BITS_NINE : BITS_EIGHT;
                    end
                end
                TX_SHIFT: begin
                    if (bit_tick) begin
                        if (bits_left == 4'h0) begin
                            tx_state <= TX_IDLE;
                        end else begin
                            tx_line            <= transmit_shift_reg[0];
                            transmit_shift_reg <= {1'b1, transmit_shift_reg[9:1]};
                            bits_left          <= 4'(bits_left - 4'h1);
                        end
                    end
                end
                default: tx_state <= TX_IDLE;
            endcase
        end
    end

    // Calibration machine
    always_ff @(posedge mclk) begin
        if (reset) begin
            rx_prev   <= 1'b1;
            abd_state <= ABD_OFF;
            edge_cnt  <= 3'h0;
        end else begin
            rx_prev <= rx_line;
            if (!autobaud_arm || sync_mode) begin
                abd_state <= ABD_OFF;
            end else begin
                case (abd_state)
                    ABD_OFF: begin
                        abd_state <= wake_on_break_enable ? ABD_BRK_WAIT
                                                          : ABD_START;
                    end
                    ABD_BRK_WAIT: if (rx_fall) begin
                        abd_state <= ABD_BRK_LOW;
                    end
                    ABD_BRK_LOW: if (rx_rise) begin
                        abd_state <= ABD_START;
                    end
                    ABD_START: if (rx_fall) begin
                        abd_state <= ABD_FIRST;
                    end
                    ABD_FIRST: if (rx_rise) begin
                        abd_state <= ABD_COUNT;
                        edge_cnt  <= 3'h1;
                    end
                    ABD_COUNT: if (rx_rise) begin
                        if (abd_done) begin
                            abd_state <= ABD_OFF;
                        end
                        edge_cnt <= 3'(edge_cnt + 3'h1);
                    end
                    default: abd_state <= ABD_OFF;
                endcase
            end
        end
    end

    // Receive flag: set at calibration end, cleared by buffer read
    always_ff @(posedge mclk) begin
        if (reset) begin
            receive_flag <= 1'b0;
        end else if (abd_done) begin
            receive_flag <= 1'b1;
        end else if (rd && (addr == ADDR_RX_BUFFER)) begin
            receive_flag <= 1'b0;
        end
    end

    // Read data, one cycle after the strobe
    always_ff @(posedge mclk) begin
        if (reset || !rd) begin
            rdata <= 8'h00;
        end else begin
            case (addr)
                ADDR_TX_STATUS: rdata <= {1'b0, nine_bit_tx_enable, transmit_enable,
                                          sync_mode, 1'b0, high_speed_baud_select,
                                          (tx_state == TX_IDLE),
                                          tx_ninth_bit_value};
                ADDR_PORT_CTRL: rdata <= {serial_port_enable, 7'h00};
                ADDR_BAUD_CTRL: rdata <= {autobaud_overflow_flag, 3'h0, wide_divisor_select,
                                          1'b0, wake_on_break_enable, autobaud_arm};
                ADDR_DIV_LOW:   rdata <= baud_divisor_low;
                ADDR_DIV_HIGH:  rdata <= baud_divisor_high;
                ADDR_REQUEST:   rdata <= {2'b00, receive_flag,
                                          transmit_buffer_empty_flag, 4'h0};
                default:        rdata <= 8'h00;
            endcase
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    a_tx_idle_high: assert property ((tx_state == TX_IDLE) && !tx_load |=> tx_line)
        else $error("line not high while idle");
    a_load_empties: assert property (tx_load |=> !buf_full ##1 transmit_buffer_empty_flag)
        else $error("buffer not emptied by load");
    a_flag_lags: assert property ($rose(buf_full) |=> !transmit_buffer_empty_flag)
        else $error("empty flag not cleared after write");
    a_shift_busy: assert property (tx_load |=> (tx_state == TX_SHIFT) && !tx_line)
        else $error("start bit missing after load");
    a_transmit_enable_sets: assert property ($rose(transmit_enable) |=> transmit_buffer_empty_flag)
        else $error("enable did not set empty flag");
    a_armed_refuse: assert property (autobaud_arm && wr && addr == ADDR_TX_BUFFER
                                     |=> buf_full == $past(buf_full))
        else $error("buffer accepted write while armed");
    a_arm_clears: assert property (abd_arm_write
                                   |=> {baud_divisor_high, baud_divisor_low} == 16'h0000)
        else $error("divisor not cleared on arm");
    a_abd_done: assert property (abd_done |=> !autobaud_arm && receive_flag
                                 && abd_state == ABD_OFF)
        else $error("calibration end not flagged");
    a_ovf_stays: assert property (abd_counting && presc_tick
                                  && {baud_divisor_high, baud_divisor_low} == DIV_MAX
                                  |=> autobaud_overflow_flag && autobaud_arm)
        else $error("overflow not trapped");

    c_frame_sent: cover property (tx_load ##[1:1000] (tx_state == TX_IDLE));
    c_abd_done: cover property (abd_done);
    c_abd_overflow: cover property ($rose(autobaud_overflow_flag));

endmodule

`default_nettype wire

// ---- include/esp_pkg.sv ----
// Purpose: constants shared by the enhanced serial port transmitter and autobaud logic
// Assumes: 8-bit register port, mclk acts as the oscillator clock
// Notes:   register offsets and bit positions are used by the design and the bench
package esp_pkg;

    // Register indices on the 3-bit address port
    localparam logic [2:0] ADDR_TX_STATUS   = 3'h0;
    localparam logic [2:0] ADDR_PORT_CTRL   = 3'h1;
    localparam logic [2:0] ADDR_BAUD_CTRL   = 3'h2;
    localparam logic [2:0] ADDR_DIV_LOW     = 3'h3;
    localparam logic [2:0] ADDR_DIV_HIGH    = 3'h4;
    localparam logic [2:0] ADDR_TX_BUFFER   = 3'h5;
    localparam logic [2:0] ADDR_RX_BUFFER   = 3'h6;
    localparam logic [2:0] ADDR_REQUEST     = 3'h7;

    // transmit_status_control bits
    localparam int BIT_NINE_BIT      = 6;
    localparam int BIT_TX_ENABLE     = 5;
    localparam int BIT_SYNC_MODE     = 4;
    localparam int BIT_HIGH_SPEED    = 2;
    localparam int BIT_SHIFT_EMPTY   = 1;
    localparam int BIT_NINTH_VALUE   = 0;
    // port control bits
    localparam int BIT_PORT_ENABLE   = 7;
    // baud_control_reg bits
    localparam int BIT_ABD_OVERFLOW  = 7;
    localparam int BIT_WIDE_DIVISOR  = 3;
    localparam int BIT_WAKE_ON_BREAK = 1;
    localparam int BIT_AUTOBAUD_ARM  = 0;
    // peripheral_request_reg_one bits
    localparam int BIT_RX_FLAG       = 5;
    localparam int BIT_TX_EMPTY_FLAG = 4;

    localparam logic [7:0] RESET_BYTE = 8'h00;

    // Oscillator clocks per divisor step, minus one
    localparam logic [9:0] PRESC_X64  = 10'h03F;
    localparam logic [9:0] PRESC_X16  = 10'h00F;
    localparam logic [9:0] PRESC_X4   = 10'h003;
    // Calibration counter runs eight times slower
    localparam int         ABD_SLOW_SHIFT = 3;

    // Frame bit counts after the start bit (data plus stop)
    localparam logic [3:0] BITS_EIGHT = 4'h9;
    localparam logic [3:0] BITS_NINE  = 4'hA;
    // Rising edges already counted when the next rise ends calibration (first edge counted as one)
    localparam logic [2:0] ABD_LAST_EDGE = 3'h4;
    localparam logic [15:0] DIV_MAX = 16'hFFFF;

    typedef enum logic [0:0] {
        TX_IDLE  = 1'b0,
        TX_SHIFT = 1'b1
    } esp_tx_state_t;

    typedef enum logic [2:0] {
        ABD_OFF      = 3'b000,
        ABD_BRK_WAIT = 3'b001,
        ABD_BRK_LOW  = 3'b010,
        ABD_START    = 3'b011,
        ABD_FIRST    = 3'b100,
        ABD_COUNT    = 3'b101
    } esp_abd_state_t;

endpackage

// ---- tb/esp_remote_node.sv ----
// Purpose: far-side serial node, sends calibration bytes and collects frames
// Assumes: frames sampled at mid-bit using bit_len mclk cycles per bit
// Notes:   each frame stored as data bits with the stop bit just above them
`timescale 1ns/1ps
`default_nettype none

module esp_remote_node (
    // Clock
    input  wire logic        mclk,
    // Frame format of the device transmitter
    input  wire logic [15:0] bit_len,
    input  wire logic        nine,
    // Serial lines
    input  wire logic        tx_line,
    output logic             rx_line
);
    logic [9:0] got_q[$];

    initial rx_line = 1'b1;

    // Start, data LSB first, stop; line idles high after the frame
    task automatic send_byte(input logic [7:0] b, input int len);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge mclk);
            rx_line <= f[i];
            repeat (len - 1) @(posedge mclk);
        end
    endtask

    initial begin
        forever begin
            logic [9:0] v;
            int         n;
            @(negedge tx_line);
            n = nine ? 9 : 8;
            v = '0;
            repeat (bit_len / 2) @(posedge mclk);
            for (int i = 0; i <= n; i++) begin
                repeat (bit_len) @(posedge mclk);
                v[i] = tx_line;
            end
            got_q.push_back(v);
        end
    end
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// Purpose: self-checking bench for the serial transmitter and autobaud logic
// Assumes: register port with read data in the cycle after the strobe
// Notes:   random divisors and data from a fixed seed
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import esp_pkg::*;
    logic        mclk, reset, wr, rd, rx_line, tx_line, nine;
    logic [2:0]  addr;
    logic [7:0]  wdata, rdata, v;
    logic [15:0] bit_len;
    int          seed, n_mismatch, checks_done, cyc;

    esp_serial_port dut_u (.mclk(mclk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .rx_line(rx_line), .tx_line(tx_line));
    esp_remote_node node_u (.mclk(mclk), .bit_len(bit_len), .nine(nine),
        .tx_line(tx_line), .rx_line(rx_line));

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            n_mismatch++;
            test_done();
        end
    end

    task automatic chk(input string nm, input logic [9:0] exp, input logic [9:0] got);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a; wdata <= d; wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
        @(posedge mclk);
        addr <= a; rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    // Calibration counter period in mclk per wide/high-speed selection
    function automatic int abd_div(input logic w, input logic h);
        return (w & h) ? 32 : ((w | h) ? 128 : 512);
    endfunction

    task test_done;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        logic [7:0] d, dat;
        logic       nn, nb;
        logic [9:0] e;
        int         ex, i;
        seed = 32'h2225;
        {cyc, n_mismatch, checks_done} = '0;
        {wr, rd, addr, wdata, nine} = '0;
        bit_len = 16'h0004;
        reset = 1'b1;
        repeat (3) @(posedge mclk);
        reset <= 1'b0;
        #1 chk("tx_idle", 1, tx_line);
        rd_reg(ADDR_TX_STATUS, v);
        chk("shift_empty", 1, v[BIT_SHIFT_EMPTY]);
        rd_reg(ADDR_REQUEST, v);
        chk("flag_reset", 0, v[BIT_TX_EMPTY_FLAG]);
        wr_reg(ADDR_PORT_CTRL, 8'h80);
        for (int m = 0; m < 4; m++) begin
            wr_reg(ADDR_TX_STATUS, {5'h04, m[0], 2'h0});
            wr_reg(ADDR_BAUD_CTRL, {4'h0, m[1], 3'h1});
            wr_reg(ADDR_TX_BUFFER, 8'hA5);
            node_u.send_byte(8'h55, 512);
            repeat (4) @(posedge mclk);
            ex = 4096 / abd_div(m[1], m[0]);
            rd_reg(ADDR_DIV_LOW, v);
            chk("abd_count", 1, (v >= ex - 1 && v <= ex + 1));
            rd_reg(ADDR_DIV_HIGH, v);
            chk("abd_high", 0, v);
            rd_reg(ADDR_BAUD_CTRL, v);
            chk("arm_clear", 0, v[BIT_AUTOBAUD_ARM]);
            rd_reg(ADDR_REQUEST, v);
            chk("rx_flag", 1, v[BIT_RX_FLAG]);
            rd_reg(ADDR_RX_BUFFER, v);
            rd_reg(ADDR_REQUEST, v);
            chk("rx_clear", 0, v[BIT_RX_FLAG]);
            $display("autobaud mode %0d done", m);
        end
        // Break first, then calibrate on the following byte
        wr_reg(ADDR_BAUD_CTRL, 8'h0B);
        node_u.send_byte(8'h00, 64);
        node_u.send_byte(8'h55, 64);
        repeat (4) @(posedge mclk);
        rd_reg(ADDR_DIV_LOW, v);
        chk("wake_count", 1, (v >= 15 && v <= 17));
        rd_reg(ADDR_BAUD_CTRL, v);
        chk("wake_arm_clear", 0, v[BIT_AUTOBAUD_ARM]);
        $display("wake calibration done");
        chk("tx_refused", 0, node_u.got_q.size());
        wr_reg(ADDR_TX_STATUS, 8'h04);
        wr_reg(ADDR_TX_STATUS, 8'h24);
        rd_reg(ADDR_REQUEST, v);
        chk("flag_enable", 1, v[BIT_TX_EMPTY_FLAG]);
        for (int k = 0; k < 6; k++) begin
            d = $random(seed) & 8'h07;
            dat = $random(seed);
            nb = $random(seed);
            nn = (k >= 3);
            bit_len = 16'(4 * (d + 1));
            nine = nn;
            wr_reg(ADDR_DIV_LOW, d);
            wr_reg(ADDR_DIV_HIGH, 8'h00);
            wr_reg(ADDR_BAUD_CTRL, 8'h08);
            wr_reg(ADDR_TX_STATUS, {1'b0, nn, 4'h9, 1'b0, nb});
            wr_reg(ADDR_TX_BUFFER, dat);
            wr_reg(ADDR_TX_BUFFER, ~dat);
            rd_reg(ADDR_REQUEST, v);
            chk("flag_full", 0, v[BIT_TX_EMPTY_FLAG]);
            for (i = 0; i < 600; i++) begin
                rd_reg(ADDR_TX_STATUS, v);
                if (v[BIT_SHIFT_EMPTY] === 1'b1 && node_u.got_q.size() == 2)
                    break;
            end
            e = nn ? {1'b1, nb, dat} : {2'b01, dat};
            chk("frame_a", e, node_u.got_q.pop_front());
            e[7:0] = ~dat;
            chk("frame_b", e, node_u.got_q.pop_front());
            $display("frame pair %0d done", k);
        end
        wr_reg(ADDR_TX_BUFFER, 8'h00);
        repeat (6) @(posedge mclk);
        wr_reg(ADDR_PORT_CTRL, 8'h00);
        repeat (2) @(posedge mclk);
        #1 chk("tx_disabled", 1, tx_line);
        $display("disable test done");
        test_done();
    end
endmodule
`default_nettype wire
